/* File: hdl/mtd_top.sv */
/*
 Memory-op and trap decode: classifies each issued operation, raises traps,
 steers prefetches and picks address spaces; AHB-Lite control/status slave.
 Assumes one pre-classified request per cycle, synchronous to i_sys_clk.
*/
// Function
// - Only IEEE and unimplemented-op floating trap types are ever produced.
// - Reading the absent deferred floating queue traps as illegal.
// - Instruction-space flush ignores its address and never faults.
// - Barrier then flush makes earlier code changes visible system-wide.
// - Codes 0-3 and 10-17 prefetch into L2; 4 and 18-1F do nothing.
// - Codes 5-F trap illegal; no other prefetch trap exists.
// - Prefetch is weak: dropped silently on translation miss or bypass.
// - Alternate prefetch works for all implemented spaces at any privilege.
// - No instruction prefetch, not even from predicted-never branches.
// - Twin-word loads and stores execute directly in hardware.
// - Doubleword floating access 32- but not 64-bit aligned traps.
// - Quad floating loads and stores trap illegal.
// - Total store order, but block operations use relaxed order.
// - Above trap level 0 use kernel spaces; data space follows endian bit.
// - User mode above trap level 0 fetches without access exception.
// - Block operations move 64 bytes through eight double registers.
// - No 8/16/32-bit partial stores to memory.
// - No 8/16-bit loads or stores to floating registers.
// - Unimplemented opcodes in either implementation space trap illegal.
// - Quad floating operates raise other-floating trap with type 3.
// - Trap type field, read-only, bits 16:14, written on floating traps.
`timescale 1ns/100ps
`default_nettype none
module mtd_top
	import mtd_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire mtd_req_t i_req,
	output var mtd_rsp_t o_rsp,
	output logic [2:0] o_ftt,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp
);
	mtd_state_t state;
	mtd_state_t next_state;
	mtd_pf_t pf_action;
	mtd_ctx_t alt_ctx;
	mtd_rsp_t r;
	logic tl_raised;
	logic addr_phase;
	logic ctrl_wr_now;
	logic pf_enable_now;
	logic [31:0] rd_value;

	mtd_pf_decode u_pf_decode (
		.i_fcn(i_req.fcn),
		.o_action(pf_action)
	);

	mtd_asi_ctx u_asi_ctx (
		.i_asi(i_req.asi),
		.o_ctx(alt_ctx)
	);

	assign tl_raised = (i_req.trap_level != 3'h0);
	assign addr_phase = i_hsel && i_hready && i_htrans[1];
	// Write data arrive a cycle after the address; forward them to a read
	assign ctrl_wr_now = state.wr_pend && (state.wr_addr == MTD_ADDR_CTRL);
	assign pf_enable_now = ctrl_wr_now ? i_hwdata[MTD_CTRL_PF_EN_BIT] : state.pf_enable;

	always_comb begin
		rd_value = 32'h0000_0000;
		case (i_haddr)
			MTD_ADDR_CTRL: begin
				rd_value[MTD_CTRL_PF_EN_BIT] = pf_enable_now;
			end
			MTD_ADDR_STATUS: begin
				rd_value[MTD_STAT_BARRIER_BIT] = state.barrier_seen;
				rd_value[MTD_STAT_FTT_LSB +: 3] = state.ftt;
			end
			MTD_ADDR_DROPS: begin
				rd_value[MTD_DROP_CNT_W-1:0] = state.drop_cnt;
			end
			default: begin
				rd_value = 32'h0000_0000;
			end
		endcase
	end

	always_comb begin
		next_state = state;
		r = '0;
		r.valid = i_req.valid;
		r.trap = TRAP_NONE;
		r.ftt = MTD_FTT_NONE;
		r.ctx = CTX_NONE;
		r.order = ORD_TSO;
		r.fetch_ok = 1'b1;
		// Implicit space above trap level 0 for ordinary data access
		if (tl_raised) begin
			r.asi = i_req.cle ? MTD_ASI_KERNEL_LE : MTD_ASI_KERNEL;
		end else begin
			r.asi = MTD_ASI_PRIMARY;
		end
		if (i_req.alt) begin
			r.asi = i_req.asi;
		end
		if (i_req.valid) begin
			case (i_req.op)
				OP_FPOP: begin
					r.execute = 1'b1;
					if (i_req.ieee_exc) begin
						r.trap = TRAP_FP_IEEE;
						r.ftt = MTD_FTT_IEEE;
					end
				end
				OP_FPOP_QUAD: begin
					r.trap = TRAP_FP_OTHER;
					r.ftt = MTD_FTT_UNIMP;
				end
				OP_PRIVILEGED_REGISTER_READ_INSTR_FQ: begin
					r.trap = TRAP_ILLEGAL;
				end
				OP_MEMBAR_SS: begin
					r.execute = 1'b1;
					next_state.barrier_seen = 1'b1;
				end
				OP_FLUSH: begin
					// Address not examined at all, so no access fault is possible
					r.execute = 1'b1;
					r.sys_sync = state.barrier_seen;
					next_state.barrier_seen = 1'b0;
				end
				OP_PREFETCH, OP_ALTERNATE_SPACE_PREFETCH: begin
					if (pf_action == PF_ILLEGAL) begin
						r.trap = TRAP_ILLEGAL;
					end else if (pf_action == PF_L2) begin
						if (i_req.op == OP_ALTERNATE_SPACE_PREFETCH) begin
							r.ctx = alt_ctx;
						end else begin
							r.ctx = tl_raised ? CTX_KERNEL : CTX_PRIMARY;
						end
						// Weak: any miss or bypass drops it, never a fault
						if (!i_req.mmu_hit || i_req.mmu_bypass || r.ctx == CTX_NONE ||
							!state.pf_enable) begin
							r.pf_dropped = 1'b1;
							next_state.drop_cnt = state.drop_cnt + 1'b1;
						end else begin
							r.l2_prefetch = 1'b1;
						end
					end
				end
				OP_BRANCH_PN: begin
					// Never starts a fetch from its target
					r.execute = 1'b1;
				end
				OP_TWIN_WORD_LOAD, OP_TWIN_WORD_STORE: begin
					r.execute = 1'b1;
				end
				OP_FP_LDD, OP_FP_STD: begin
					if (i_req.addr_lo[1:0] != 2'h0) begin
						r.trap = TRAP_MISALIGN;
					end else if (i_req.addr_lo[2]) begin
						r.trap = (i_req.op == OP_FP_LDD) ? TRAP_FP_DOUBLEWORD_LOAD_ALIGN :
							TRAP_FP_DOUBLEWORD_STORE_ALIGN;
					end else begin
						r.execute = 1'b1;
					end
				end
				OP_FP_LDQ, OP_FP_STQ: begin
					r.trap = TRAP_ILLEGAL;
				end
				OP_BLOCK_LD, OP_BLOCK_ST: begin
					r.execute = 1'b1;
					r.order = ORD_RMO;
					r.blk_bytes = MTD_BLK_BYTES;
					r.blk_fp_regs = MTD_BLK_FP_REGS;
				end
				OP_PARTIAL_ST: begin
					r.trap = TRAP_ILLEGAL;
				end
				OP_FP_SHORT: begin
					r.trap = TRAP_ILLEGAL;
				end
				OP_IMPL_DEFINED_OPCODE_SPACE_ONE, OP_IMPL_DEFINED_OPCODE_SPACE_TWO: begin
					r.trap = TRAP_ILLEGAL;
				end
				OP_LOAD, OP_STORE: begin
					r.execute = 1'b1;
				end
				OP_IFETCH: begin
					r.execute = 1'b1;
					if (tl_raised) begin
						r.asi = MTD_ASI_KERNEL;
						r.iae_suppressed = !i_req.priv;
					end
					r.fetch_ok = 1'b1;
				end
				default: begin
					r.execute = 1'b0;
				end
			endcase
		end
		// Only the two floating trap kinds ever update the trap type field
		if (r.trap == TRAP_FP_IEEE || r.trap == TRAP_FP_OTHER) begin
			next_state.ftt = r.ftt;
		end
		next_state.rsp = r;

		// Bus slave: zero wait states, always OKAY
		next_state.hreadyout = 1'b1;
		next_state.hresp = 1'b0;
		if (ctrl_wr_now) begin
			next_state.pf_enable = i_hwdata[MTD_CTRL_PF_EN_BIT];
		end
		next_state.wr_pend = addr_phase && i_hwrite;
		if (addr_phase) begin
			next_state.wr_addr = i_haddr;
		end
		if (addr_phase && !i_hwrite) begin
			next_state.hrdata = rd_value;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state <= '0;
			state.pf_enable <= MTD_CTRL_PF_EN_RST;
			state.hreadyout <= 1'b1;
			state.ftt <= MTD_FTT_NONE;
		end else begin
			state <= next_state;
		end
	end

	assign o_rsp = state.rsp;
	assign o_ftt = state.ftt;
	assign o_hrdata = state.hrdata;
	assign o_hreadyout = state.hreadyout;
	assign o_hresp = state.hresp;
endmodule
`default_nettype wire

/* File: hdl/mtd_pkg.sv */
/*
 Shared types and constants for the memory-op and trap decode block.
 Assumes the issue pipeline presents one pre-classified operation per cycle.
*/
`default_nettype none
package mtd_pkg;
	// Register map on the AHB-Lite slave
	localparam logic [31:0] MTD_ADDR_CTRL = 32'h0000_0000;
	localparam logic [31:0] MTD_ADDR_STATUS = 32'h0000_0004;
	localparam logic [31:0] MTD_ADDR_DROPS = 32'h0000_0008;
	localparam int MTD_CTRL_PF_EN_BIT = 0;
	localparam logic MTD_CTRL_PF_EN_RST = 1'b1;
	localparam int MTD_STAT_BARRIER_BIT = 0;
	localparam int MTD_STAT_FTT_LSB = 14;
	localparam int MTD_DROP_CNT_W = 16;
	// Floating-point trap type field values
	localparam logic [2:0] MTD_FTT_NONE = 3'h0;
	localparam logic [2:0] MTD_FTT_IEEE = 3'h1;
	localparam logic [2:0] MTD_FTT_UNIMP = 3'h3;
	// Address spaces
	localparam logic [7:0] MTD_ASI_KERNEL = 8'h04;
	localparam logic [7:0] MTD_ASI_KERNEL_LE = 8'h0C;
	localparam logic [7:0] MTD_ASI_PRIMARY = 8'h80;
	// Block operation geometry
	localparam logic [6:0] MTD_BLK_BYTES = 7'h40;
	localparam logic [3:0] MTD_BLK_FP_REGS = 4'h8;

	typedef enum logic [4:0] {
		OP_NONE, OP_FPOP, OP_FPOP_QUAD, OP_PRIVILEGED_REGISTER_READ_INSTR_FQ, OP_FLUSH, OP_MEMBAR_SS,
		OP_PREFETCH, OP_ALTERNATE_SPACE_PREFETCH, OP_BRANCH_PN, OP_TWIN_WORD_LOAD, OP_TWIN_WORD_STORE,
		OP_FP_LDD, OP_FP_STD, OP_FP_LDQ, OP_FP_STQ, OP_BLOCK_LD, OP_BLOCK_ST,
		OP_PARTIAL_ST, OP_FP_SHORT, OP_IMPL_DEFINED_OPCODE_SPACE_ONE, OP_IMPL_DEFINED_OPCODE_SPACE_TWO, OP_LOAD, OP_STORE,
		OP_IFETCH
	} mtd_op_t;
	typedef enum logic [2:0] {
		TRAP_NONE, TRAP_ILLEGAL, TRAP_FP_IEEE, TRAP_FP_OTHER, TRAP_FP_DOUBLEWORD_LOAD_ALIGN,
		TRAP_FP_DOUBLEWORD_STORE_ALIGN, TRAP_MISALIGN
	} mtd_trap_t;
	typedef enum logic [1:0] {CTX_NONE, CTX_PRIMARY, CTX_SECONDARY, CTX_KERNEL} mtd_ctx_t;
	typedef enum logic [1:0] {PF_L2, PF_NOP, PF_ILLEGAL} mtd_pf_t;
	typedef enum logic {ORD_TSO, ORD_RMO} mtd_order_t;

	typedef struct packed {
		logic valid;
		mtd_op_t op;
		logic alt;
		logic [4:0] fcn;
		logic [7:0] asi;
		logic [2:0] addr_lo;
		logic ieee_exc;
		logic [2:0] trap_level;
		logic priv;
		logic cle;
		logic mmu_hit;
		logic mmu_bypass;
	} mtd_req_t;

	typedef struct packed {
		logic valid;
		mtd_trap_t trap;
		logic [2:0] ftt;
		logic execute;
		logic l2_prefetch;
		logic pf_dropped;
		mtd_ctx_t ctx;
		logic [7:0] asi;
		mtd_order_t order;
		logic [6:0] blk_bytes;
		logic [3:0] blk_fp_regs;
		logic sys_sync;
		logic fetch_ok;
		logic iae_suppressed;
	} mtd_rsp_t;

	typedef struct packed {
		mtd_rsp_t rsp;
		logic [2:0] ftt;
		logic barrier_seen;
		logic pf_enable;
		logic [MTD_DROP_CNT_W-1:0] drop_cnt;
		logic wr_pend;
		logic [31:0] wr_addr;
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
	} mtd_state_t;
endpackage
`default_nettype wire

/* File: hdl/mtd_pf_decode.sv */
/*
 Prefetch function-code decode.
 Assumes a 5-bit function code; purely combinational.
*/
`timescale 1ns/100ps
`default_nettype none
module mtd_pf_decode
	import mtd_pkg::*;
(
	input wire logic [4:0] i_fcn,
	output var mtd_pf_t o_action
);
	always_comb begin
		case (i_fcn) inside
			[5'h00:5'h03]: begin
				o_action = PF_L2;
			end
			5'h04: begin
				o_action = PF_NOP;
			end
			[5'h05:5'h0F]: begin
				o_action = PF_ILLEGAL;
			end
			[5'h10:5'h17]: begin
				o_action = PF_L2;
			end
			default: begin
				o_action = PF_NOP;
			end
		endcase
	end
endmodule
`default_nettype wire

/* File: hdl/mtd_asi_ctx.sv */
/*
 Context lookup for alternate-space prefetch.
 Assumes an 8-bit address-space identifier; unlisted values give no context.
*/
`timescale 1ns/100ps
`default_nettype none
module mtd_asi_ctx
	import mtd_pkg::*;
(
	input wire logic [7:0] i_asi,
	output var mtd_ctx_t o_ctx
);
	always_comb begin
		case (i_asi)
			8'h10, 8'h16, 8'h18, 8'h1E, 8'h22, 8'h2A, 8'h80, 8'h82, 8'h88, 8'h8A,
			8'hC0, 8'hC2, 8'hC4, 8'hC8, 8'hCA, 8'hCC, 8'hD0, 8'hD2, 8'hD8, 8'hDA,
			8'hE0, 8'hE2, 8'hEA, 8'hF0, 8'hF8: begin
				o_ctx = CTX_PRIMARY;
			end
			8'h11, 8'h17, 8'h19, 8'h1F, 8'h23, 8'h2B, 8'h81, 8'h83, 8'h89, 8'h8B,
			8'hC1, 8'hC3, 8'hC5, 8'hC9, 8'hCB, 8'hCD, 8'hD1, 8'hD3, 8'hD9, 8'hDB,
			8'hE1, 8'hE3, 8'hEB, 8'hF1, 8'hF9: begin
				o_ctx = CTX_SECONDARY;
			end
			8'h04, 8'h0C, 8'h14, 8'h15, 8'h1C, 8'h1D, 8'h20, 8'h21, 8'h24, 8'h25,
			8'h26, 8'h27, 8'h2C, 8'h2E, 8'h2F, 8'h31, 8'h32, 8'h33, 8'h35, 8'h36,
			8'h37, 8'h39, 8'h3A, 8'h3B, 8'h3D, 8'h3E, 8'h3F, 8'h40, 8'h42, 8'h43,
			8'h44, 8'h45, 8'h46, 8'h47, 8'h4B, 8'h4C, 8'h4D, 8'h4F, 8'h50, 8'h51,
			8'h52, 8'h54, 8'h55, 8'h56, 8'h57, 8'h58, 8'h59, 8'h5A, 8'h5B, 8'h5C,
			8'h5D, 8'h5E, 8'h5F, 8'h60, 8'h66, 8'h67, 8'h72, 8'h73, 8'h74: begin
				o_ctx = CTX_KERNEL;
			end
			default: begin
				o_ctx = CTX_NONE;
			end
		endcase
	end
endmodule
`default_nettype wire

/* File: verification/mtd_chk_monitor.sv */
/*
 Concurrent checks on the decode ports of mtd_top, attached by bind.
 Assumes one clock domain and the active-low asynchronous reset.
*/
`timescale 1ns/100ps
`default_nettype none
module mtd_chk_monitor
	import mtd_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire mtd_req_t i_req,
	input wire mtd_rsp_t o_rsp,
	input wire logic [2:0] o_ftt
);
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_b);
	wire logic v = i_req.valid;
	wire mtd_op_t op = i_req.op;
	wire logic pf = v && op inside {OP_PREFETCH, OP_ALTERNATE_SPACE_PREFETCH};
	wire logic tl = i_req.trap_level != 3'h0;
	chk_ftt_codes: assert property (o_ftt inside {3'h0, 3'h1, 3'h3})
		else $error("trap type code not allowed");
	chk_flush_safe: assert property (v && op == OP_FLUSH |=> o_rsp.trap == TRAP_NONE)
		else $error("flush trapped");
	chk_sync_pair: assert property (v && op == OP_MEMBAR_SS ##1 v && op == OP_FLUSH
		|=> o_rsp.sys_sync) else $error("flush after barrier not synced");
	chk_pf_trap: assert property (pf |=> o_rsp.trap ==
		(($past(i_req.fcn) inside {[5:15]}) ? TRAP_ILLEGAL : TRAP_NONE)) else $error("prefetch trap");
	chk_pf_weak: assert property (pf && (!i_req.mmu_hit || i_req.mmu_bypass)
		|=> !o_rsp.l2_prefetch) else $error("prefetch not dropped");
	chk_quad_mem: assert property (v && op inside {OP_FP_LDQ, OP_FP_STQ}
		|=> o_rsp.trap == TRAP_ILLEGAL) else $error("quad access not trapped");
	chk_quad_op: assert property (v && op == OP_FPOP_QUAD
		|=> o_rsp.trap == TRAP_FP_OTHER && o_rsp.ftt == 3'h3) else $error("quad op trap");
	chk_kernel_space: assert property (v && op inside {OP_LOAD, OP_STORE} && tl
		|=> o_rsp.asi == ($past(i_req.cle) ? MTD_ASI_KERNEL_LE : MTD_ASI_KERNEL))
		else $error("data space wrong");
	chk_fetch_ovr: assert property (v && op == OP_IFETCH && tl && !i_req.priv
		|=> o_rsp.fetch_ok && o_rsp.iae_suppressed) else $error("fetch not allowed");
	chk_ftt_hold: assert property (!(v && op inside {OP_FPOP, OP_FPOP_QUAD})
		|=> $stable(o_ftt)) else $error("trap type changed");
endmodule
bind mtd_top mtd_chk_monitor i_mtd_chk_monitor (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
	.i_req(i_req), .o_rsp(o_rsp), .o_ftt(o_ftt));
`default_nettype wire

/* File: verification/mtd_l2_model.sv */
/*
 Far side of mtd_top: load/store path and L2 cache, counting what it is asked to do.
 Assumes each decode answer stands for exactly one cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module mtd_l2_model
	import mtd_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire mtd_rsp_t i_rsp,
	output var int o_pf_cnt,
	output var int o_sync_cnt
);
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_pf_cnt <= 0;
			o_sync_cnt <= 0;
		end else if (i_rsp.valid) begin
			// Memory to L2 only, never back out
			o_pf_cnt <= o_pf_cnt + int'(i_rsp.l2_prefetch);
			o_sync_cnt <= o_sync_cnt + int'(i_rsp.sys_sync);
		end
	end
endmodule
`default_nettype wire

/* File: verification/tb.sv */
/*
 Self-checking bench for mtd_top: seeded random and corner decode traffic, AHB-Lite registers.
 Assumes a zero-wait slave and a decode answer one cycle after each request.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
	$display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb
	import mtd_pkg::*;
;
	logic clk, rst_b, hsel, hwrite, pend, pf_en, hresp;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, rd, d0;
	logic [2:0] ftt, exp_ftt;
	wire logic hrdy;
	mtd_req_t req, prev;
	mtd_rsp_t rsp;
	int num_errors, num_checks, exp_pf, pf_cnt, sync_cnt;
	logic [4:0] tab_f [8] = '{5'h03, 5'h04, 5'h05, 5'h0f, 5'h10, 5'h17, 5'h18, 5'h1f};
	logic [7:0] tab_a [4] = '{8'h10, 8'h11, 8'h04, 8'h2d};
	mtd_top i_mtd_top (.i_sys_clk(clk), .i_rst_b(rst_b), .i_req(req), .o_rsp(rsp), .o_ftt(ftt),
		.i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
		.i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp));
	mtd_l2_model i_mtd_l2_model (.i_sys_clk(clk), .i_rst_b(rst_b), .i_rsp(rsp),
		.o_pf_cnt(pf_cnt), .o_sync_cnt(sync_cnt));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic results();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hrdy !== 1'b1 && n < 50);
		if (hrdy !== 1'b1) begin
			num_errors++;
			results();
		end
	endtask
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		hsel <= 1'b1;
		wait_rdy();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		wait_rdy();
		rd = hrdata;
		`CHK("hresp", 1'b0, hresp)
	endtask
	task automatic send(input mtd_req_t r);
		@(posedge clk);
		req <= r;
	endtask
	function automatic mtd_req_t mk(input mtd_op_t op, input logic [4:0] f, input logic [7:0] a);
		mtd_req_t r;
		r = '0;
		r.valid = 1'b1;
		r.op = op;
		r.alt = op == OP_ALTERNATE_SPACE_PREFETCH;
		r.fcn = f;
		r.asi = a;
		r.mmu_hit = 1'b1;
		return r;
	endfunction
	function automatic mtd_req_t rnd();
		mtd_req_t r;
		logic [7:0] tab [4] = '{8'h10, 8'h11, 8'h04, 8'h2d};
		r = mk(mtd_op_t'(1 + $urandom % 23), 5'($urandom), tab[$urandom % 4]);
		r.valid = $urandom % 4 != 0;
		if (r.op inside {OP_FP_LDD, OP_FP_STD, OP_FLUSH}) r.addr_lo = 3'($urandom);
		r.ieee_exc = r.op == OP_FPOP && 1'($urandom);
		r.trap_level = 3'($urandom % 3);
		r.priv = 1'($urandom);
		r.cle = 1'($urandom);
		r.mmu_hit = $urandom % 4 != 0;
		r.mmu_bypass = $urandom % 4 == 0;
		return r;
	endfunction
	function automatic mtd_trap_t exp_trap(input mtd_req_t r);
		case (r.op)
			OP_FPOP: return r.ieee_exc ? TRAP_FP_IEEE : TRAP_NONE;
			OP_FPOP_QUAD: return TRAP_FP_OTHER;
			OP_PRIVILEGED_REGISTER_READ_INSTR_FQ, OP_FP_LDQ, OP_FP_STQ, OP_PARTIAL_ST, OP_FP_SHORT, OP_IMPL_DEFINED_OPCODE_SPACE_ONE,
			OP_IMPL_DEFINED_OPCODE_SPACE_TWO: return TRAP_ILLEGAL;
			OP_PREFETCH, OP_ALTERNATE_SPACE_PREFETCH: return r.fcn inside {[5:15]} ? TRAP_ILLEGAL : TRAP_NONE;
			OP_FP_LDD, OP_FP_STD: begin
				if (r.addr_lo[1:0] != 2'h0) return TRAP_MISALIGN;
				if (!r.addr_lo[2]) return TRAP_NONE;
				return r.op == OP_FP_LDD ? TRAP_FP_DOUBLEWORD_LOAD_ALIGN : TRAP_FP_DOUBLEWORD_STORE_ALIGN;
			end
			default: return TRAP_NONE;
		endcase
	endfunction
	function automatic logic pf_hit(input mtd_req_t r);
		logic ok;
		ok = r.op == OP_PREFETCH || (r.op == OP_ALTERNATE_SPACE_PREFETCH && r.asi inside {8'h10, 8'h11, 8'h04});
		return ok && pf_en && r.mmu_hit && !r.mmu_bypass && r.fcn inside {[0:3], [16:23]};
	endfunction
	function automatic mtd_ctx_t exp_ctx(input mtd_req_t r);
		if (r.op == OP_PREFETCH) return r.trap_level != 3'h0 ? CTX_KERNEL : CTX_PRIMARY;
		return r.asi == 8'h10 ? CTX_PRIMARY : r.asi == 8'h11 ? CTX_SECONDARY : CTX_KERNEL;
	endfunction
	task automatic check(input mtd_req_t r);
		logic hit;
		logic [7:0] asi;
		hit = pf_hit(r);
		asi = r.trap_level == 3'h0 ? MTD_ASI_PRIMARY : (r.cle && r.op != OP_IFETCH) ?
			MTD_ASI_KERNEL_LE : MTD_ASI_KERNEL;
		`CHK("valid", r.valid, rsp.valid)
		if (r.valid) begin
			`CHK("trap", exp_trap(r), rsp.trap)
			`CHK("l2", hit, rsp.l2_prefetch)
			if (hit) `CHK("ctx", exp_ctx(r), rsp.ctx)
			if (r.op inside {OP_PREFETCH, OP_ALTERNATE_SPACE_PREFETCH}) `CHK("drop", !hit && r.fcn inside {[0:3], [16:23]}, rsp.pf_dropped)
			exp_pf += int'(hit);
			if (r.op == OP_FPOP_QUAD) exp_ftt = MTD_FTT_UNIMP;
			if (r.op == OP_FPOP && r.ieee_exc) exp_ftt = MTD_FTT_IEEE;
			`CHK("ftt", exp_ftt, ftt)
			if (r.op == OP_FLUSH) `CHK("sync", pend, rsp.sys_sync)
			if (r.op == OP_FLUSH) pend = 1'b0;
			if (r.op == OP_MEMBAR_SS) pend = 1'b1;
			if (r.op inside {OP_LOAD, OP_STORE, OP_IFETCH}) `CHK("asi", asi, rsp.asi)
			if (r.op inside {OP_LOAD, OP_STORE}) `CHK("tso", ORD_TSO, rsp.order)
			if (r.op == OP_IFETCH) `CHK("iae", r.trap_level != 0 && !r.priv, rsp.iae_suppressed)
			if (r.op inside {OP_BLOCK_LD, OP_BLOCK_ST}) `CHK("blk", {ORD_RMO, MTD_BLK_BYTES,
				MTD_BLK_FP_REGS}, {rsp.order, rsp.blk_bytes, rsp.blk_fp_regs})
			if (r.op inside {OP_TWIN_WORD_LOAD, OP_TWIN_WORD_STORE}) `CHK("exec", 1'b1, rsp.execute)
		end
	endtask
	// Response read before the edge's own updates land
	always @(posedge clk) begin
		if (rst_b) check(prev);
		prev <= req;
	end
	initial begin
		rst_b = 1'b0;
		req = '0;
		prev = '0;
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		{exp_ftt, pend, pf_en, exp_pf, num_errors, num_checks} = '0;
		pf_en = 1'b1;
		void'($urandom(62));
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		ahb(1'b0, MTD_ADDR_CTRL, 32'h0000_0000);
		`CHK("ctrl", 32'h0000_0001, rd)
		ahb(1'b1, 32'h0000_0010, 32'hffff_ffff);
		ahb(1'b0, 32'h0000_0010, 32'h0000_0000);
		`CHK("unmapped", 32'h0000_0000, rd)
		repeat (600) send(rnd());
		foreach (tab_f[i]) send(mk(OP_PREFETCH, tab_f[i], 8'h00));
		foreach (tab_a[i]) send(mk(OP_ALTERNATE_SPACE_PREFETCH, 5'h00, tab_a[i]));
		send(mk(OP_FPOP_QUAD, 5'h00, 8'h00));
		send(mk(OP_MEMBAR_SS, 5'h00, 8'h00));
		send('0);
		ahb(1'b0, MTD_ADDR_STATUS, 32'h0000_0000);
		`CHK("status", {exp_ftt, 1'b1}, {rd[16:14], rd[0]})
		send(mk(OP_FLUSH, 5'h00, 8'h00));
		send(mk(OP_FLUSH, 5'h00, 8'h00));
		send('0);
		ahb(1'b0, MTD_ADDR_DROPS, 32'h0000_0000);
		d0 = rd;
		ahb(1'b1, MTD_ADDR_CTRL, 32'h0000_0000);
		pf_en = 1'b0;
		foreach (tab_f[i]) send(mk(OP_PREFETCH, tab_f[i], 8'h00));
		send('0);
		ahb(1'b0, MTD_ADDR_DROPS, 32'h0000_0000);
		// Only legal L2 codes count as drops
		`CHK("drops", d0 + 32'h0000_0003, rd)
		ahb(1'b1, MTD_ADDR_CTRL, 32'h0000_0001);
		pf_en = 1'b1;
		repeat (2) @(posedge clk);
		`CHK("pf_cnt", exp_pf, pf_cnt)
		results();
	end
endmodule
`default_nettype wire
